// File: common/fprg_pkg.sv
// Shared constants and types for the FIFO programming-register block
package fprg_pkg;
  // ----------------------------------------------------------------------
  // Widths and register layout
  // ----------------------------------------------------------------------
  localparam int DATA_W = 18;
  localparam int ADDR_W_DEF = 9;
  localparam int CTRL_ACTIVE_W = 6;
  localparam logic [DATA_W-1:0] CTRL_RST_COMPAT = 18'h00000;
  localparam logic [DATA_W-1:0] CTRL_RST_ENH = 18'h0003f;
  localparam int OFFSET_DIV = 8;

  // ----------------------------------------------------------------------
  // Register-access pointer positions
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FPRG_SEL_AE,
    FPRG_SEL_AF,
    FPRG_SEL_CTRL
  } fprg_sel_t;

  // ----------------------------------------------------------------------
  // Grouping modes latched at reset
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FPRG_GRP_STANDALONE,
    FPRG_GRP_PARALLEL,
    FPRG_GRP_CASC_FIRST,
    FPRG_GRP_CASC_FOLLOW
  } fprg_grp_t;

  typedef struct packed {
    logic [DATA_W-1:0] almost_empty_offset;
    logic [DATA_W-1:0] almost_full_offset;
    logic [DATA_W-1:0] feature_control;
  } fprg_cfg_t;
endpackage : fprg_pkg

// File: core/fprg_regs.sv
// Programmable offset/control registers, retransmit and grouping-mode latch
`timescale 1ns/1ns

module fprg_regs #(
  parameter int ADDR_W = fprg_pkg::ADDR_W_DEF
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic enhanced_select_n_i,
  input wire logic register_select_n_i,
  input wire logic write_enable_n_i,
  input wire logic read_enable_n_i,
  input wire logic write_expand_in_enable2_i,
  input wire logic read_expand_in_enable2_i,
  input wire logic first_load_retransmit_i,
  input wire logic [fprg_pkg::DATA_W-1:0] data_in_bus_i,
  input wire logic write_expand_src_n_i,
  input wire logic read_expand_src_n_i,
  output logic [fprg_pkg::DATA_W-1:0] data_out_bus_o,
  output logic reg_read_valid_o,
  output logic array_write_o,
  output logic array_read_o,
  output logic read_ptr_reload_o,
  output logic enhanced_mode_o,
  output fprg_pkg::fprg_grp_t grouping_mode_o,
  output fprg_pkg::fprg_cfg_t config_o,
  output logic write_expand_out_half_flag_o,
  output logic read_expand_out_empty2_o
);
  localparam logic [fprg_pkg::DATA_W-1:0] OFF_MASK = fprg_pkg::DATA_W'((1 << ADDR_W) - 1);
  localparam logic [fprg_pkg::DATA_W-1:0] OFF_RST =
    fprg_pkg::DATA_W'((1 << ADDR_W) / fprg_pkg::OFFSET_DIV - 1);
  localparam logic [fprg_pkg::DATA_W-1:0] CTRL_MASK =
    fprg_pkg::DATA_W'((1 << fprg_pkg::CTRL_ACTIVE_W) - 1);

  fprg_pkg::fprg_sel_t wr_sel;
  fprg_pkg::fprg_sel_t rd_sel;
  fprg_pkg::fprg_sel_t next_wr_sel;
  fprg_pkg::fprg_sel_t next_rd_sel;
  logic enhanced_select_n;
  logic wen_eff;
  logic ren_eff;
  logic reg_wr;
  logic reg_rd;
  logic cascaded;

  // ----------------------------------------------------------------------
  // Qualified enables
  // ----------------------------------------------------------------------
  // Enable-2 only gates in enhanced mode; in compatible mode the pin is an expansion input
  assign wen_eff = !write_enable_n_i && (!enhanced_select_n || write_expand_in_enable2_i);
  assign ren_eff = !read_enable_n_i && (!enhanced_select_n || read_expand_in_enable2_i);
  assign reg_wr = !register_select_n_i && wen_eff;
  assign reg_rd = !register_select_n_i && ren_eff;
  assign cascaded = (grouping_mode_o == fprg_pkg::FPRG_GRP_CASC_FIRST) ||
                    (grouping_mode_o == fprg_pkg::FPRG_GRP_CASC_FOLLOW);
  assign enhanced_mode_o = enhanced_select_n;

  always_comb begin
    case (wr_sel)
      fprg_pkg::FPRG_SEL_AE: next_wr_sel = fprg_pkg::FPRG_SEL_AF;
      fprg_pkg::FPRG_SEL_AF: next_wr_sel = enhanced_select_n ? fprg_pkg::FPRG_SEL_CTRL
                                                 : fprg_pkg::FPRG_SEL_AE;
      default: next_wr_sel = fprg_pkg::FPRG_SEL_AE;
    endcase
  end

  always_comb begin
    case (rd_sel)
      fprg_pkg::FPRG_SEL_AE: next_rd_sel = fprg_pkg::FPRG_SEL_AF;
      fprg_pkg::FPRG_SEL_AF: next_rd_sel = enhanced_select_n ? fprg_pkg::FPRG_SEL_CTRL
                                                 : fprg_pkg::FPRG_SEL_AE;
      default: next_rd_sel = fprg_pkg::FPRG_SEL_AE;
    endcase
  end

  // ----------------------------------------------------------------------
  // Mode straps, caught while reset is held
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      enhanced_select_n <= !enhanced_select_n_i;
      if (!write_expand_in_enable2_i && !read_expand_in_enable2_i) begin
        grouping_mode_o <= fprg_pkg::FPRG_GRP_STANDALONE;
      end else if (!enhanced_select_n_i) begin
        grouping_mode_o <= fprg_pkg::FPRG_GRP_PARALLEL;
      end else if (!first_load_retransmit_i) begin
        grouping_mode_o <= fprg_pkg::FPRG_GRP_CASC_FIRST;
      end else begin
        grouping_mode_o <= fprg_pkg::FPRG_GRP_CASC_FOLLOW;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Write side: pointer and registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_sel <= fprg_pkg::FPRG_SEL_AE;
      config_o.almost_empty_offset <= OFF_RST;
      config_o.almost_full_offset <= OFF_RST;
      config_o.feature_control <= enhanced_select_n_i ? fprg_pkg::CTRL_RST_COMPAT
                                                      : fprg_pkg::CTRL_RST_ENH;
    end else if (clk_en_i && reg_wr) begin
      wr_sel <= next_wr_sel;
      case (wr_sel)
        fprg_pkg::FPRG_SEL_AE: config_o.almost_empty_offset <= data_in_bus_i & OFF_MASK;
        fprg_pkg::FPRG_SEL_AF: config_o.almost_full_offset <= data_in_bus_i & OFF_MASK;
        default: config_o.feature_control <= data_in_bus_i & CTRL_MASK;
      endcase
    end
  end

  // Array write strobe for the storage logic; suppressed during register loads
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      array_write_o <= 1'b0;
    end else if (clk_en_i) begin
      array_write_o <= register_select_n_i && wen_eff;
    end
  end

  // ----------------------------------------------------------------------
  // Read side: pointer and output word
  // ----------------------------------------------------------------------
  // Reading and writing one register in the same cycle returns the old value
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_sel <= fprg_pkg::FPRG_SEL_AE;
      data_out_bus_o <= 18'h00000;
      reg_read_valid_o <= 1'b0;
      array_read_o <= 1'b0;
    end else if (clk_en_i) begin
      reg_read_valid_o <= reg_rd;
      array_read_o <= register_select_n_i && ren_eff;
      if (reg_rd) begin
        rd_sel <= next_rd_sel;
        case (rd_sel)
          fprg_pkg::FPRG_SEL_AE: data_out_bus_o <= config_o.almost_empty_offset;
          fprg_pkg::FPRG_SEL_AF: data_out_bus_o <= config_o.almost_full_offset;
          default: data_out_bus_o <= config_o.feature_control;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Retransmit and expansion outputs
  // ----------------------------------------------------------------------
  // Write pointer is untouched: only a reload strobe for the read pointer leaves here
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      read_ptr_reload_o <= 1'b0;
    end else if (clk_en_i) begin
      read_ptr_reload_o <= first_load_retransmit_i && !cascaded;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      write_expand_out_half_flag_o <= 1'b1;
      read_expand_out_empty2_o <= 1'b1;
    end else if (clk_en_i) begin
      write_expand_out_half_flag_o <= write_expand_src_n_i;
      read_expand_out_empty2_o <= read_expand_src_n_i;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_qual_wr;
    clk_en_i && reg_wr;
  endsequence

  sequence s_qual_rd;
    clk_en_i && reg_rd;
  endsequence

  AST_RST_CTRL_COMPAT: assert property (@(posedge clk_sys_i)
    rst_i && enhanced_select_n_i |=> config_o.feature_control == 18'h00000)
    else $error("control not cleared by compatible reset");
  AST_RST_CTRL_ENH: assert property (@(posedge clk_sys_i)
    rst_i && !enhanced_select_n_i |=> config_o.feature_control == 18'h0003f)
    else $error("control reset value wrong in enhanced mode");
  AST_RST_DEFAULTS: assert property (@(posedge clk_sys_i)
    rst_i |=> config_o.almost_empty_offset == OFF_RST && config_o.almost_full_offset == OFF_RST
      && wr_sel == fprg_pkg::FPRG_SEL_AE && rd_sel == fprg_pkg::FPRG_SEL_AE)
    else $error("reset defaults wrong");
  AST_WR_AE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_qual_wr ##0 (wr_sel == fprg_pkg::FPRG_SEL_AE)
      |=> config_o.almost_empty_offset == ($past(data_in_bus_i) & OFF_MASK))
    else $error("almost-empty offset not written");
  AST_WR_SEQ: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_qual_wr ##0 (wr_sel == fprg_pkg::FPRG_SEL_AF)
      |=> wr_sel == (enhanced_select_n ? fprg_pkg::FPRG_SEL_CTRL : fprg_pkg::FPRG_SEL_AE))
    else $error("write pointer sequence wrong");
  AST_WR_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !register_select_n_i && write_enable_n_i |=> $stable(wr_sel) && $stable(config_o))
    else $error("register changed without write enable");
  AST_RD_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !register_select_n_i && read_enable_n_i |=> $stable(rd_sel) && $stable(data_out_bus_o))
    else $error("register read without read enable");
  AST_RD_SEQ: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_qual_rd ##0 (rd_sel == fprg_pkg::FPRG_SEL_AF)
      |=> data_out_bus_o == $past(config_o.almost_full_offset) && reg_read_valid_o)
    else $error("almost-full offset not presented");
  AST_RETX: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && first_load_retransmit_i && cascaded |=> !read_ptr_reload_o)
    else $error("retransmit acted in cascade");
  AST_EXP_RST: assert property (@(posedge clk_sys_i)
    rst_i |=> write_expand_out_half_flag_o && read_expand_out_empty2_o)
    else $error("expansion outputs not high after reset");
  AST_WEN2: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && enhanced_select_n && !write_expand_in_enable2_i |=> !array_write_o && $stable(wr_sel))
    else $error("enable-2 did not gate write");

  // ----------------------------------------------------------------------
  // Checks: access-pointer cycles and data paths
  // ----------------------------------------------------------------------
  // Pointer cycles span several accesses, so they are built from these steps
  sequence s_wr_at_ae;
    s_qual_wr ##0 (wr_sel == fprg_pkg::FPRG_SEL_AE);
  endsequence

  sequence s_wr_at_ctrl;
    s_qual_wr ##0 (wr_sel == fprg_pkg::FPRG_SEL_CTRL);
  endsequence

  sequence s_rd_at_ae;
    s_qual_rd ##0 (rd_sel == fprg_pkg::FPRG_SEL_AE);
  endsequence

  sequence s_rd_at_ctrl;
    s_qual_rd ##0 (rd_sel == fprg_pkg::FPRG_SEL_CTRL);
  endsequence

  sequence s_two_wr_from_ae;
    s_wr_at_ae ##1 s_qual_wr;
  endsequence

  sequence s_three_wr_from_ae;
    s_two_wr_from_ae ##1 s_qual_wr;
  endsequence

  AST_WR_AF: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_qual_wr ##0 (wr_sel == fprg_pkg::FPRG_SEL_AF)
      |=> config_o.almost_full_offset == ($past(data_in_bus_i) & OFF_MASK))
    else $error("almost-full offset not written");
  AST_WR_CTRL: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_wr_at_ctrl |=> config_o.feature_control == ($past(data_in_bus_i) & CTRL_MASK))
    else $error("control register not written");
  AST_WR_COMPAT_WRAP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !enhanced_select_n ##0 s_two_wr_from_ae |=> wr_sel == fprg_pkg::FPRG_SEL_AE)
    else $error("compatible write pointer did not wrap after two writes");
  AST_WR_ENH_WRAP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    enhanced_select_n ##0 s_three_wr_from_ae |=> wr_sel == fprg_pkg::FPRG_SEL_AE)
    else $error("enhanced write pointer did not wrap after three writes");
  AST_RD_AE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_rd_at_ae |=> data_out_bus_o == $past(config_o.almost_empty_offset) && reg_read_valid_o)
    else $error("almost-empty offset not presented");
  AST_RD_CTRL: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_rd_at_ctrl |=> data_out_bus_o == $past(config_o.feature_control)
      && rd_sel == fprg_pkg::FPRG_SEL_AE)
    else $error("control register not presented");
  AST_RD_WRAP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !enhanced_select_n ##0 s_qual_rd ##0 (rd_sel == fprg_pkg::FPRG_SEL_AF)
      |=> rd_sel == fprg_pkg::FPRG_SEL_AE)
    else $error("compatible read pointer did not wrap");
  AST_RD_ZERO_FILL: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    reg_read_valid_o |-> (data_out_bus_o & ~OFF_MASK) == 18'h00000)
    else $error("register word not zero-filled");
  AST_VALID_PULSE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && !reg_rd |=> !reg_read_valid_o)
    else $error("read valid without a register read");
  AST_ARR_WR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && register_select_n_i && wen_eff |=> array_write_o)
    else $error("array write strobe missing");
  AST_ARR_RD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && register_select_n_i && ren_eff |=> array_read_o)
    else $error("array read strobe missing");
  AST_REG_NO_ARR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && !register_select_n_i |=> !array_write_o && !array_read_o)
    else $error("array strobe during register access");
  AST_RETX_RELOAD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && first_load_retransmit_i && !cascaded |=> read_ptr_reload_o)
    else $error("retransmit did not reload read pointer");
  AST_REN2: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && enhanced_select_n && !read_expand_in_enable2_i
      |=> !array_read_o && !reg_read_valid_o && $stable(rd_sel))
    else $error("read enable-2 did not gate read");
  AST_CE_FREEZE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !clk_en_i |=> $stable(config_o) && $stable(wr_sel) && $stable(rd_sel)
      && $stable(data_out_bus_o))
    else $error("state moved with clock enable low");
  AST_GRP_STANDALONE: assert property (@(posedge clk_sys_i)
    rst_i && !write_expand_in_enable2_i && !read_expand_in_enable2_i
      |=> grouping_mode_o == fprg_pkg::FPRG_GRP_STANDALONE)
    else $error("standalone grouping not latched");
  AST_ENHANCED_SELECT_N_LATCH: assert property (@(posedge clk_sys_i)
    rst_i |=> enhanced_mode_o != $past(enhanced_select_n_i))
    else $error("enhanced mode not latched at reset");
  AST_EXP_FOLLOW: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i |=> write_expand_out_half_flag_o == $past(write_expand_src_n_i)
      && read_expand_out_empty2_o == $past(read_expand_src_n_i))
    else $error("expansion outputs do not follow their sources");
endmodule : fprg_regs

// File: sim/fprg_host.sv
// Host model that drives the pins of the FIFO programming-register block
`timescale 1ns/1ns
module fprg_host (
  input wire logic clk_sys_i,
  output logic ce_o,
  output logic enhanced_select_n_n_o,
  output logic sel_n_o,
  output logic wen_n_o,
  output logic ren_n_o,
  output logic wx_o,
  output logic rx_o,
  output logic flr_o,
  output logic wsrc_n_o,
  output logic rsrc_n_o,
  output logic [fprg_pkg::DATA_W-1:0] din_o
);
  // ----------------------------------------------------------------------
  // Pin drivers, set at time zero and then changed just after a rising edge
  // ----------------------------------------------------------------------
  initial begin
    {ce_o, enhanced_select_n_n_o, sel_n_o, wen_n_o, ren_n_o, wsrc_n_o, rsrc_n_o} = 7'h7f;
    {wx_o, rx_o, flr_o} = 3'h0;
    din_o = 18'h00000;
  end
  // Straps are what the board holds during reset
  task automatic strap(input logic [4:0] s);
    @(posedge clk_sys_i);
    {ce_o, enhanced_select_n_n_o, wx_o, rx_o, flr_o} <= s;
  endtask : strap
  // Register read and write are never requested together; arr(2'b00) drives both enables for the array at once
  task automatic wr(input logic [17:0] d);
    @(posedge clk_sys_i);
    {sel_n_o, wen_n_o, ren_n_o} <= 3'b001;
    din_o <= d & 18'h003ff; // Bits 17:10 always go out as zero; bit 9 passes through
  endtask : wr
  task automatic rd();
    @(posedge clk_sys_i);
    {sel_n_o, wen_n_o, ren_n_o} <= 3'b010;
  endtask : rd
  task automatic hold(input int n);
    @(posedge clk_sys_i);
    {sel_n_o, wen_n_o, ren_n_o} <= 3'b011;
    repeat (n) @(posedge clk_sys_i);
  endtask : hold
  task automatic arr(input logic [1:0] wr_n);
    @(posedge clk_sys_i);
    {sel_n_o, wen_n_o, ren_n_o} <= {1'b1, wr_n};
  endtask : arr
  task automatic rt();
    @(posedge clk_sys_i);
    flr_o <= 1'b1;
    @(posedge clk_sys_i);
    flr_o <= 1'b0;
  endtask : rt
  task automatic src(input logic [1:0] s);
    @(posedge clk_sys_i);
    {wsrc_n_o, rsrc_n_o} <= s;
  endtask : src
endmodule : fprg_host

// File: sim/fprg_regs_test.sv
// Self-checking bench for the FIFO programming-register block
`timescale 1ns/1ns
module fprg_regs_test;
  // ----------------------------------------------------------------------
  // Wiring
  // ----------------------------------------------------------------------
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce, enhanced_select_n_n, sel_n, wen_n, ren_n, wx, rx, flr, wsrc_n, rsrc_n;
  logic [fprg_pkg::DATA_W-1:0] din, dout;
  logic vld, awr, ard, rld, enh, wxo, rxo;
  fprg_pkg::fprg_grp_t grp;
  fprg_pkg::fprg_cfg_t cfg;
  int err_count = 0;
  int compares = 0;
  logic [17:0] exp_q[$];
  logic [6:0] tbl[3] = '{{5'b10111, fprg_pkg::FPRG_GRP_PARALLEL},
    {5'b11110, fprg_pkg::FPRG_GRP_CASC_FIRST}, {5'b11111, fprg_pkg::FPRG_GRP_CASC_FOLLOW}};
  always #5 clk_sys_i = ~clk_sys_i;
  fprg_host fprg_host_i (.clk_sys_i(clk_sys_i), .ce_o(ce), .enhanced_select_n_n_o(enhanced_select_n_n),
    .sel_n_o(sel_n), .wen_n_o(wen_n), .ren_n_o(ren_n), .wx_o(wx), .rx_o(rx),
    .flr_o(flr), .wsrc_n_o(wsrc_n), .rsrc_n_o(rsrc_n), .din_o(din));
  fprg_regs #(.ADDR_W(9)) fprg_regs_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .clk_en_i(ce), .enhanced_select_n_i(enhanced_select_n_n), .register_select_n_i(sel_n),
    .write_enable_n_i(wen_n), .read_enable_n_i(ren_n), .write_expand_in_enable2_i(wx),
    .read_expand_in_enable2_i(rx), .first_load_retransmit_i(flr), .data_in_bus_i(din),
    .write_expand_src_n_i(wsrc_n), .read_expand_src_n_i(rsrc_n), .data_out_bus_o(dout),
    .reg_read_valid_o(vld), .array_write_o(awr), .array_read_o(ard),
    .read_ptr_reload_o(rld), .enhanced_mode_o(enh), .grouping_mode_o(grp),
    .config_o(cfg), .write_expand_out_half_flag_o(wxo), .read_expand_out_empty2_o(rxo));
  // ----------------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------------
  task automatic chk(input logic [53:0] g, input logic [53:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // A valid with nothing expected is forced to mismatch
  always @(negedge clk_sys_i) begin
    if (vld === 1'b1) begin
      if (exp_q.size() == 0) exp_q.push_back(~dout);
      chk({36'h0, dout}, {36'h0, exp_q.pop_front()});
    end
  end
  task automatic rdx(input logic [17:0] e);
    exp_q.push_back(e);
    fprg_host_i.rd();
  endtask : rdx
  task automatic do_reset(input logic [4:0] s);
    fprg_host_i.strap(s);
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1;
  endtask : do_reset
  task automatic drain();
    fprg_host_i.hold(0);
    repeat (2) @(posedge clk_sys_i);
    chk(54'(exp_q.size()), 54'h0);
  endtask : drain
  initial begin
    #200000;
    chk(54'h1, 54'h0);
    report_and_stop();
  end
  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    do_reset(5'b11000);
    chk(cfg, {18'h0003f, 18'h0003f, 18'h00000});
    chk({49'h0, enh, grp, wxo, rxo}, 54'h3);
    fprg_host_i.wr(18'h001a5);
    fprg_host_i.wr(18'h000f0);
    fprg_host_i.wr(18'h00133);
    fprg_host_i.hold(2);
    fprg_host_i.wr(18'h000c3);
    fprg_host_i.arr(2'b00);
    fprg_host_i.arr(2'b11);
    #1;
    chk(cfg, {18'h00133, 18'h000c3, 18'h00000});
    chk({52'h0, awr, ard}, 54'h3);
    rdx(18'h00133);
    rdx(18'h000c3);
    rdx(18'h00133);
    fprg_host_i.hold(3);
    rdx(18'h000c3);
    drain();
    fprg_host_i.rt();
    #1;
    chk({53'h0, rld}, 54'h1);
    fprg_host_i.rt();
    #1;
    chk({53'h0, rld}, 54'h1);
    fprg_host_i.src(2'b01);
    @(posedge clk_sys_i);
    #1;
    chk({52'h0, wxo, rxo}, 54'h1);
    fprg_host_i.src(2'b10);
    @(posedge clk_sys_i);
    #1;
    chk({52'h0, wxo, rxo}, 54'h2);
    $display("test compatible done");
    do_reset(5'b10000);
    chk(cfg, {18'h0003f, 18'h0003f, 18'h0003f});
    chk({53'h0, enh}, 54'h1);
    fprg_host_i.wr(18'h00077);
    fprg_host_i.strap(5'b00110);
    fprg_host_i.wr(18'h00078);
    fprg_host_i.hold(0);
    fprg_host_i.strap(5'b10110);
    fprg_host_i.wr(18'h00011);
    fprg_host_i.wr(18'h00022);
    fprg_host_i.wr(18'h0002a);
    fprg_host_i.wr(18'h00055);
    fprg_host_i.arr(2'b11);
    #1;
    chk(cfg, {18'h00055, 18'h00022, 18'h0002a});
    rdx(18'h00055);
    rdx(18'h00022);
    rdx(18'h0002a);
    rdx(18'h00055);
    drain();
    $display("test enhanced done");
    for (int i = 0; i < 3; i++) begin
      do_reset(tbl[i][6:2]);
      chk({50'h0, grp, wxo, rxo}, {50'h0, tbl[i][1:0], 2'b11});
    end
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk({53'h0, rld}, 54'h0);
    $display("test grouping done");
    report_and_stop();
  end
endmodule : fprg_regs_test
